// *** common/port_edge_pkg.sv ***
// constants, register map and carrier types for the port edge/direction block
// Notes on behaviour
// - with its polarity bit at 1, a rising edge on an edge pin sets that pin's flag.
// - with its polarity bit at 1, the pin's pull device is a pull-down, on only if enabled and the pin is an input.
// - with its polarity bit at 0, a falling edge on an edge pin sets that pin's flag.
// - with its polarity bit at 0, the pin's pull device is a pull-up, on only if enabled and the pin is an input.
// - a pin's enable bit at 1 lets its flag request an interrupt; at 0 the flag is masked.
// - while the assigned serial interface is enabled, pin 1 of the pair drives as an output.
// - while the assigned serial interface is enabled, pin 0 of the pair is an input.
// - an enabled routed second SPI, with the serial interface off, sets each pin's direction from its own setting; stored bits stay.
// - once the overriding peripheral is off, the stored direction bits rule again.
// - with no override, a direction bit of 1 makes an output and 0 an input.
// - after a direction change the readback of the pins may lag by up to 2 bus clocks.
// - polarity and enable registers may be read and written at any time.
package port_edge_pkg;
    localparam int EDGE_PINS = 8;
    localparam int PAIR_PINS = 2;
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_POLARITY = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_INT_ENABLE = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_INT_FLAGS = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_PULL_ENABLE = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_DIRECTION = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_PAIR_STATUS = 5'h14;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // pair status field positions
    localparam int ST_OE_LSB = 0;
    localparam int ST_IN_LSB = 2;
    localparam int ST_SERIAL = 4;
    localparam int ST_SPI = 5;
    localparam int SYNC_STAGES = 2;

    typedef struct packed {
        logic enable;
        logic [PAIR_PINS-1:0] drive_out;
    } spi_override_s;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avs_req_s;
endpackage

// *** rtl/edge_event_detect.sv ***
// per-pin synchroniser and polarity-selected edge detector
`timescale 1ns/1ps
`default_nettype none
module edge_event_detect (
    input wire logic i_clk_sys, // bus clock
    input wire logic i_reset, // sync reset, high
    input wire logic [port_edge_pkg::EDGE_PINS-1:0] i_pins, // edge pins
    input wire logic [port_edge_pkg::EDGE_PINS-1:0] i_polarity, // 1 rising, 0 falling
    output logic [port_edge_pkg::EDGE_PINS-1:0] o_event // one-cycle edge pulses
);
    logic [port_edge_pkg::EDGE_PINS-1:0] meta_q;
    logic [port_edge_pkg::EDGE_PINS-1:0] sync_q;
    logic [port_edge_pkg::EDGE_PINS-1:0] prev_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            meta_q <= port_edge_pkg::RST_BYTE;
            sync_q <= port_edge_pkg::RST_BYTE;
            prev_q <= port_edge_pkg::RST_BYTE;
        end else begin
            meta_q <= i_pins;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < port_edge_pkg::EDGE_PINS; g++) begin : g_pin
            // polarity picks the edge; changing it while the pin is steady never looks like an edge
            assign o_event[g] = i_polarity[g] ? (sync_q[g] & ~prev_q[g])
                                              : (~sync_q[g] & prev_q[g]);
        end
    endgenerate

    a_rise_event: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_polarity[0] && sync_q[0] && !prev_q[0]) |-> o_event[0])
        else $error("rising edge missed on pin 0");
    a_fall_event: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (!i_polarity[0] && $fell(sync_q[0])) |-> o_event[0])
        else $error("falling edge missed on pin 0");
endmodule
`default_nettype wire

// *** rtl/pair_direction_mux.sv ***
// direction select for the two low pins of the second port
`timescale 1ns/1ps
`default_nettype none
module pair_direction_mux (
    input wire logic [port_edge_pkg::PAIR_PINS-1:0] i_dir_bits, // stored direction
    input wire logic i_serial_en, // assigned serial interface on
    input wire port_edge_pkg::spi_override_s i_spi, // routed spi override
    output logic [port_edge_pkg::PAIR_PINS-1:0] o_drive_out // 1 output, 0 input
);
    // serial takes precedence if both are on; software should not enable both
    always_comb begin
        if (i_serial_en) begin
            o_drive_out = 2'b10;
        end else if (i_spi.enable) begin
            o_drive_out = i_spi.drive_out;
        end else begin
            o_drive_out = i_dir_bits;
        end
    end
endmodule
`default_nettype wire

// *** rtl/port_pin_edge_irq_and_direction.sv ***
// edge interrupt port and second-port pair direction control, Avalon-MM slave
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module port_pin_edge_irq_and_direction (
    input wire logic i_clk_sys, // 40 MHz bus clock
    input wire logic i_reset, // sync reset, high
    input wire logic [port_edge_pkg::ADDR_W-1:0] i_avs_address, // byte address
    input wire logic i_avs_read, // read request
    input wire logic i_avs_write, // write request
    input wire logic [31:0] i_avs_writedata, // write data
    input wire logic [3:0] i_avs_byteenable, // byte lanes
    output logic [31:0] o_avs_readdata, // read data
    output logic o_avs_waitrequest, // high until accepted
    input wire logic [port_edge_pkg::EDGE_PINS-1:0] i_edge_pins, // edge port pin levels
    input wire logic [port_edge_pkg::EDGE_PINS-1:0] i_edge_port_dir, // 1 pin is output
    output logic [port_edge_pkg::EDGE_PINS-1:0] o_pull_on, // pull device connected
    output logic [port_edge_pkg::EDGE_PINS-1:0] o_pull_down, // 1 down, 0 up
    output logic o_irq, // port interrupt, level
    input wire logic i_serial_en, // assigned serial interface on
    input wire port_edge_pkg::spi_override_s i_spi, // routed spi override
    input wire logic [port_edge_pkg::PAIR_PINS-1:0] i_pair_pins, // pair pin levels
    output logic [port_edge_pkg::PAIR_PINS-1:0] o_pair_oe // pair output enables
);
    port_edge_pkg::avs_req_s req;
    logic [7:0] polarity_q;
    logic [7:0] int_enable_q;
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] pull_enable_q;
    logic [7:0] direction_q;
    logic [7:0] events;
    logic [1:0] drive_out;
    logic [1:0] pair_meta_q;
    logic [1:0] pair_sync_q;
    logic accept;
    logic wr_fire;
    logic [7:0] wbyte;
    logic wlane;
    logic [31:0] rd_d;

    // one strobe per register; an unmapped address matches none of them
    function automatic logic wr_hit(input logic fire,
                                    input logic [port_edge_pkg::ADDR_W-1:0] addr,
                                    input logic [port_edge_pkg::ADDR_W-1:0] ofs);
        return fire && (addr == ofs);
    endfunction

    assign req = '{read: i_avs_read, write: i_avs_write, address: i_avs_address,
                   writedata: i_avs_writedata, byteenable: i_avs_byteenable};
    // only lane 0 holds data; a write without lane 0 changes nothing
    assign wbyte = req.writedata[7:0];
    assign wlane = req.byteenable[0];
    assign accept = (req.read | req.write) & ~o_avs_waitrequest;
    assign wr_fire = req.write & ~o_avs_waitrequest & wlane;

    ////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, then accept at the next edge
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_avs_waitrequest <= 1'b1;
        end else if ((req.read | req.write) & o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'b0;
        end else begin
            o_avs_waitrequest <= 1'b1;
        end
    end

    always_comb begin
        rd_d = port_edge_pkg::RD_ZERO;
        unique case (req.address)
            port_edge_pkg::OFS_POLARITY: rd_d[7:0] = polarity_q;
            port_edge_pkg::OFS_INT_ENABLE: rd_d[7:0] = int_enable_q;
            port_edge_pkg::OFS_INT_FLAGS: rd_d[7:0] = flags_q;
            port_edge_pkg::OFS_PULL_ENABLE: rd_d[7:0] = pull_enable_q;
            port_edge_pkg::OFS_DIRECTION: rd_d[7:0] = direction_q;
            port_edge_pkg::OFS_PAIR_STATUS: begin
                rd_d[port_edge_pkg::ST_OE_LSB +: 2] = o_pair_oe;
                rd_d[port_edge_pkg::ST_IN_LSB +: 2] = pair_sync_q;
                rd_d[port_edge_pkg::ST_SERIAL] = i_serial_en;
                rd_d[port_edge_pkg::ST_SPI] = i_spi.enable;
            end
            default: rd_d = port_edge_pkg::RD_ZERO;
        endcase
    end

    // data is loaded in the wait cycle and held through the accept edge
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_avs_readdata <= port_edge_pkg::RD_ZERO;
        end else if (req.read & o_avs_waitrequest) begin
            o_avs_readdata <= rd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers, writable at any time
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            polarity_q <= port_edge_pkg::RST_BYTE;
        end else if (wr_hit(wr_fire, req.address, port_edge_pkg::OFS_POLARITY)) begin
            polarity_q <= wbyte;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            int_enable_q <= port_edge_pkg::RST_BYTE;
        end else if (wr_hit(wr_fire, req.address, port_edge_pkg::OFS_INT_ENABLE)) begin
            int_enable_q <= wbyte;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            pull_enable_q <= port_edge_pkg::RST_BYTE;
        end else if (wr_hit(wr_fire, req.address, port_edge_pkg::OFS_PULL_ENABLE)) begin
            pull_enable_q <= wbyte;
        end
    end

    // overrides never touch the stored bits, so they come back intact
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            direction_q <= port_edge_pkg::RST_BYTE;
        end else if (wr_hit(wr_fire, req.address, port_edge_pkg::OFS_DIRECTION)) begin
            direction_q <= wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // edge flags: write one to clear, a new edge in the same cycle wins
    edge_event_detect u_edge (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_pins(i_edge_pins),
        .i_polarity(polarity_q),
        .o_event(events)
    );

    always_comb begin
        flags_d = flags_q;
        if (wr_hit(wr_fire, req.address, port_edge_pkg::OFS_INT_FLAGS)) begin
            flags_d = flags_d & ~wbyte;
        end
        flags_d = flags_d | events;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            flags_q <= port_edge_pkg::RST_BYTE;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(flags_q & int_enable_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pull devices: polarity picks direction, enable and input use gate it
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_pull_on <= port_edge_pkg::RST_BYTE;
            o_pull_down <= port_edge_pkg::RST_BYTE;
        end else begin
            o_pull_on <= pull_enable_q & ~i_edge_port_dir;
            o_pull_down <= polarity_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pair direction and readback synchroniser
    pair_direction_mux u_dir (
        .i_dir_bits(direction_q[1:0]),
        .i_serial_en(i_serial_en),
        .i_spi(i_spi),
        .o_drive_out(drive_out)
    );

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_pair_oe <= 2'b00;
        end else begin
            o_pair_oe <= drive_out;
        end
    end

    // readback trails pin changes by the sync stages; software must wait
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            pair_meta_q <= 2'b00;
            pair_sync_q <= 2'b00;
        end else begin
            pair_meta_q <= i_pair_pins;
            pair_sync_q <= pair_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);

    a_flag_set_wins: assert property ((events != 8'h00) |=> ((flags_q & $past(events)) == $past(events)))
        else $error("edge event did not set its flag");
    a_irq_follows: assert property ((|(flags_q & int_enable_q)) |=> o_irq)
        else $error("interrupt low with enabled flag set");
    a_irq_masked: assert property ((int_enable_q == 8'h00) |=> !o_irq)
        else $error("interrupt high while all masked");
    a_serial_tx_out: assert property (i_serial_en |=> o_pair_oe[1])
        else $error("serial tx pin not output");
    a_serial_rx_in: assert property (i_serial_en |=> !o_pair_oe[0])
        else $error("serial rx pin not input");
    a_spi_force: assert property ((!i_serial_en && i_spi.enable) |=> (o_pair_oe == $past(i_spi.drive_out)))
        else $error("spi direction not applied");
    a_dir_restore: assert property ((!i_serial_en && !i_spi.enable) |=> (o_pair_oe == $past(direction_q[1:0])))
        else $error("stored direction not applied");
    a_dir_kept: assert property ((i_serial_en && !wr_fire) |=> $stable(direction_q))
        else $error("override changed stored direction");
    a_pull_select: assert property (1'b1 |=> (o_pull_down == $past(polarity_q) && o_pull_on == $past(pull_enable_q & ~i_edge_port_dir)))
        else $error("pull device wrong");
    a_wait_one: assert property (((req.read | req.write) && o_avs_waitrequest) |=> !o_avs_waitrequest)
        else $error("slave did not answer after one wait cycle");
    a_pair_lag: assert property (1'b1 |-> ##2 (pair_sync_q == $past(i_pair_pins, 2)))
        else $error("readback lag not two cycles");

    ////////////////////////////////////////////////////////////////////////
    // every pin, end to end: pin edge, two sync stages, then the flag one edge later
    genvar p;
    generate
        for (p = 0; p < port_edge_pkg::EDGE_PINS; p++) begin : g_flag_chk
            a_rise_flag: assert property (($rose(i_edge_pins[p]) && polarity_q[p])
                ##1 (polarity_q[p]) [*2] |-> ##1 flags_q[p])
                else $error("rising edge left no flag");
            a_fall_flag: assert property (($fell(i_edge_pins[p]) && !polarity_q[p])
                ##1 (!polarity_q[p]) [*2] |-> ##1 flags_q[p])
                else $error("falling edge left no flag");
            a_pin_irq: assert property ((flags_q[p] && int_enable_q[p]) |=> o_irq)
                else $error("enabled flag raised no interrupt");
        end
    endgenerate

    // bus side: writes land on the accept edge only, reads return the register
    a_write_lands: assert property (
        wr_hit(wr_fire, req.address, port_edge_pkg::OFS_POLARITY)
        |=> (polarity_q == $past(wbyte)))
        else $error("polarity write lost");
    a_dir_write: assert property (
        wr_hit(wr_fire, req.address, port_edge_pkg::OFS_DIRECTION)
        |=> (direction_q == $past(wbyte)))
        else $error("direction write lost");
    a_lane_gate: assert property (
        (req.write && !o_avs_waitrequest && !wlane)
        |=> ($stable(polarity_q) && $stable(int_enable_q) && $stable(direction_q)))
        else $error("write without lane 0 changed a register");
    a_read_enable: assert property (
        (req.read && o_avs_waitrequest && req.address == port_edge_pkg::OFS_INT_ENABLE)
        |=> (o_avs_readdata[7:0] == $past(int_enable_q)))
        else $error("enable readback wrong");
    a_read_polarity: assert property (
        (req.read && o_avs_waitrequest && req.address == port_edge_pkg::OFS_POLARITY)
        |=> (o_avs_readdata[7:0] == $past(polarity_q)))
        else $error("polarity readback wrong");
    a_read_flags: assert property (
        (req.read && o_avs_waitrequest && req.address == port_edge_pkg::OFS_INT_FLAGS)
        |=> (o_avs_readdata[7:0] == $past(flags_q)))
        else $error("flag readback wrong");
    a_read_direction: assert property (
        (req.read && o_avs_waitrequest && req.address == port_edge_pkg::OFS_DIRECTION)
        |=> (o_avs_readdata[7:0] == $past(direction_q)))
        else $error("direction readback wrong");
    a_status_read: assert property (
        (req.read && o_avs_waitrequest && req.address == port_edge_pkg::OFS_PAIR_STATUS)
        |=> (o_avs_readdata[port_edge_pkg::ST_IN_LSB +: 2] == $past(pair_sync_q)))
        else $error("pair readback wrong");
    a_wait_idle: assert property (!(req.read || req.write) |=> o_avs_waitrequest)
        else $error("waitrequest low with no request");

    // flags: a clear with no edge empties the bit, and no bit appears unasked
    a_flag_clear: assert property (
        (wr_hit(wr_fire, req.address, port_edge_pkg::OFS_INT_FLAGS) && events == 8'h00)
        |=> ((flags_q & $past(wbyte)) == 8'h00))
        else $error("flag survived a clear");
    a_no_stray_flag: assert property (
        1'b1 |=> ((flags_q & ~$past(flags_q) & ~$past(events)) == 8'h00))
        else $error("flag set with no edge");
    a_irq_drop: assert property (!(|(flags_q & int_enable_q)) |=> !o_irq)
        else $error("interrupt high with nothing enabled pending");

    // pins: pulls only on enabled inputs, overrides never touch the stored bits
    a_pull_off_out: assert property (
        1'b1 |=> ((o_pull_on & $past(i_edge_port_dir | ~pull_enable_q)) == 8'h00))
        else $error("pull device on an output or disabled pin");
    a_spi_dir_kept: assert property ((i_spi.enable && !wr_fire) |=> $stable(direction_q))
        else $error("spi override changed stored direction");
    a_serial_wins: assert property ((i_serial_en && i_spi.enable) |=> (o_pair_oe == 2'b10))
        else $error("spi overrode the serial interface");
endmodule
`default_nettype wire

// *** verification/pin_side_model.sv ***
// far-side model: edge pin levels, pair pin levels and the overriding peripherals
`timescale 1ns/1ps
`default_nettype none
module pin_side_model (
    input wire logic i_clk_sys, // bus clock
    output logic [7:0] o_edge_pins, // edge pin levels
    output logic [7:0] o_edge_dir, // edge port direction, 1 output
    output logic [1:0] o_pair_pins, // pair pin levels
    output logic o_serial_en, // assigned serial interface on
    output port_edge_pkg::spi_override_s o_spi // routed spi override
);
    initial begin
        o_edge_pins = 8'h00;
        o_edge_dir = 8'h00;
        o_pair_pins = 2'h0;
        o_serial_en = 1'b0;
        o_spi = 3'h0;
    end
    // on-chip peripherals and pin buffers change just after a bus clock edge
    task automatic drive(input logic [7:0] pins, input logic [7:0] dir, input logic [1:0] pair,
                         input logic ser, input port_edge_pkg::spi_override_s spi);
        @(posedge i_clk_sys);
        o_edge_pins <= pins;
        o_edge_dir <= dir;
        o_pair_pins <= pair;
        o_serial_en <= ser;
        o_spi <= spi;
    endtask
endmodule
`default_nettype wire

// *** verification/tb_port_pin_edge_irq_and_direction.sv ***
// self-checking bench: register access, edge flags, interrupt and pair direction
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_port_pin_edge_irq_and_direction;
    logic clk_sys;
    logic rst = 1'b1;
    logic [4:0] avs_addr = 5'h00;
    logic avs_rd = 1'b0;
    logic avs_wr = 1'b0;
    logic [31:0] avs_wdata = 32'h0000_0000;
    logic [3:0] avs_be = 4'hF;
    logic [31:0] avs_rdata;
    logic avs_wait;
    logic [7:0] edge_pins, edge_dir, pull_on, pull_down;
    logic irq, serial_en;
    logic [1:0] pair_pins, pair_oe;
    port_edge_pkg::spi_override_s spi;
    int miscompares = 0;
    int checks_done = 0;

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    pin_side_model u_pins (.i_clk_sys(clk_sys), .o_edge_pins(edge_pins), .o_edge_dir(edge_dir),
        .o_pair_pins(pair_pins), .o_serial_en(serial_en), .o_spi(spi));

    port_pin_edge_irq_and_direction u_dut (.i_clk_sys(clk_sys), .i_reset(rst),
        .i_avs_address(avs_addr), .i_avs_read(avs_rd), .i_avs_write(avs_wr),
        .i_avs_writedata(avs_wdata), .i_avs_byteenable(avs_be), .o_avs_readdata(avs_rdata),
        .o_avs_waitrequest(avs_wait), .i_edge_pins(edge_pins), .i_edge_port_dir(edge_dir),
        .o_pull_on(pull_on), .o_pull_down(pull_down), .o_irq(irq), .i_serial_en(serial_en),
        .i_spi(spi), .i_pair_pins(pair_pins), .o_pair_oe(pair_oe));

    task automatic final_report();
        $display("checks %0d, miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one idle edge first, so a release and the next request never share a time step
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        n = 0;
        avs_rd <= !w;
        avs_wr <= w;
        avs_addr <= a;
        avs_wdata <= {24'h00_0000, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_wait !== 1'b0 && n < 20);
        if (n >= 20) begin
            miscompares++;
            final_report();
        end
        q = avs_rdata;
        avs_rd <= 1'b0;
        avs_wr <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        `CHK(q, {24'h00_0000, e})
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        // every register, status and one unmapped place read zero after reset
        for (int i = 0; i < 7; i++) begin
            rd(5'(i * 4), 8'h00);
        end
        u_pins.drive(8'hF0, 8'h33, 2'h0, 1'b0, 3'h0);
        wr(port_edge_pkg::OFS_POLARITY, 8'h0F);
        wr(port_edge_pkg::OFS_PULL_ENABLE, 8'hFF);
        rd(port_edge_pkg::OFS_POLARITY, 8'h0F);
        // a write without lane 0 is answered but stores nothing
        avs_be <= 4'hE;
        wr(port_edge_pkg::OFS_POLARITY, 8'hFF);
        avs_be <= 4'hF;
        rd(port_edge_pkg::OFS_POLARITY, 8'h0F);
        idle(6);
        // a polarity change alone raises no flags; still, start from a clean slate
        wr(port_edge_pkg::OFS_INT_FLAGS, 8'hFF);
        rd(port_edge_pkg::OFS_INT_FLAGS, 8'h00);
        `CHK(pull_down, 8'h0F)
        `CHK(pull_on, 8'hCC)
        // low nibble rises, high nibble falls: every pin sees its active edge
        u_pins.drive(8'h0F, 8'h33, 2'h0, 1'b0, 3'h0);
        idle(6);
        rd(port_edge_pkg::OFS_INT_FLAGS, 8'hFF);
        wr(port_edge_pkg::OFS_INT_FLAGS, 8'hFF);
        // the opposite edges must leave the flags alone
        u_pins.drive(8'hF0, 8'h33, 2'h0, 1'b0, 3'h0);
        idle(6);
        rd(port_edge_pkg::OFS_INT_FLAGS, 8'h00);
        u_pins.drive(8'h0F, 8'h33, 2'h0, 1'b0, 3'h0);
        idle(6);
        `CHK(irq, 1'b0)
        wr(port_edge_pkg::OFS_INT_ENABLE, 8'h04);
        idle(3);
        `CHK(irq, 1'b1)
        rd(port_edge_pkg::OFS_INT_ENABLE, 8'h04);
        wr(port_edge_pkg::OFS_INT_FLAGS, 8'h04);
        idle(3);
        `CHK(irq, 1'b0)
        // pair direction: stored bits, serial override, spi override, release
        wr(port_edge_pkg::OFS_DIRECTION, 8'hA1);
        idle(3);
        `CHK(pair_oe, 2'h1)
        u_pins.drive(8'h0F, 8'h33, 2'h2, 1'b1, 3'h0);
        idle(3);
        `CHK(pair_oe, 2'h2)
        rd(port_edge_pkg::OFS_DIRECTION, 8'hA1);
        rd(port_edge_pkg::OFS_PAIR_STATUS, 8'h1A);
        // serial and spi both on: the serial interface keeps the pair
        u_pins.drive(8'h0F, 8'h33, 2'h2, 1'b1, 3'h5);
        idle(3);
        `CHK(pair_oe, 2'h2)
        u_pins.drive(8'h0F, 8'h33, 2'h1, 1'b0, 3'h7);
        idle(3);
        `CHK(pair_oe, 2'h3)
        rd(port_edge_pkg::OFS_PAIR_STATUS, 8'h27);
        u_pins.drive(8'h0F, 8'h33, 2'h1, 1'b0, 3'h0);
        idle(3);
        `CHK(pair_oe, 2'h1)
        wr(port_edge_pkg::OFS_DIRECTION, 8'h02);
        idle(3);
        `CHK(pair_oe, 2'h2)
        final_report();
    end
endmodule
`default_nettype wire
